//--- ssp_link_host.sv
/* model of the external spi host at the client pins.
   assumes the caller starts frames; the clock is still between them. */
`default_nettype none
module ssp_link_host
(
    output logic link_clk,
    output logic ss_n,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'b0;
        ss_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic frame(input logic [7:0] v, input int n, input logic sel);
        ss_n <= !sel;
        #13;
        for (int i = 7; i > 7 - n; i--) begin
            sdi = v[i];
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        #13 ss_n = 1'b1;
        sdi = ~sdi;
    endtask
    task automatic level(input logic v);
        sdi <= v;
    endtask
endmodule
`default_nettype wire

//--- ssp_pkg.sv
/*
 * package for the sleep-aware synchronous serial port: register map,
 * field positions, reset values, timing counts and carrier types.
 * assumes a 25 MHz apb clock and a client link clock from the pin.
 */
//
// Behaviour
// R1: host mode freezes whole transfer during sleep
// R2: host transfer resumes mid-byte after wake
// R3: client shift register runs on serial clock only
// R4: client byte sets flag; enabled flag wakes
// R5: disabled port interrupt keeps device asleep
// R6: software takes care with very fast port clock
// R7: full byte moves to buffer, sets flags
// R8: select high or disable clears bit counter
// R9: wake equals flag and enable, clocklessly; here cwake is a flop on link_clk set by the byte end and cien_sync
`default_nettype none
package ssp_pkg;
    localparam logic [7:0] OFF_BUF    = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_CTRL3  = 8'h08;
    localparam logic [7:0] OFF_STAT   = 8'h0c;
    localparam logic [7:0] OFF_IRQ    = 8'h10;
    localparam int BIT_WRITE_COLLISION_FLAG  = 7;
    localparam int BIT_OV    = 6;
    localparam int BIT_EN    = 5;
    localparam int BIT_CKP   = 4;
    localparam int BIT_BOEN  = 4;
    localparam int BIT_BF    = 0;
    localparam int BIT_FLAG  = 0;
    localparam int BIT_IEN   = 1;
    localparam logic [3:0] MODE_CLIENT_SEL = 4'h4;
    localparam logic [3:0] MODE_CLIENT_MIN = 4'h4;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int PCLK_MHZ = 25;
    localparam int HALF_BIT_NS = 80;
    localparam int HALF_BIT_CYC_I = (HALF_BIT_NS * PCLK_MHZ) / 1000;
    localparam logic [3:0] HALF_BIT_CYC = HALF_BIT_CYC_I[3:0];

    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_LOW   = 2'b01,
        SSP_HIGH  = 2'b10
    } ssp_host_state_t;

    typedef struct packed {
        logic       write_collision_flag;
        logic       ov;
        logic       en;
        logic       clock_polarity_bit;
        logic [3:0] mode;
    } ssp_ctrl1_t;

    typedef struct packed {
        logic       data;
        logic       clk;
    } ssp_pin_t;
endpackage
`default_nettype wire

//--- ssp_sleep_port.sv
/*
 * serial port in spi mode with sleep behaviour: apb register slave,
 * host shift engine on pclk that freezes while sleep is asserted, and
 * client shift engine on the serial clock pin that keeps running.
 * assumes sleep_req comes from pclk logic and the client clock pin is
 * wired to link_clk as well as to the pin input.
 */
// Decided for this implementation: the register offsets and the APB interface to the registers.
`default_nettype none
module ssp_sleep_port
    import ssp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        sleep_req,
    input  wire logic        link_clk,
    input  wire logic        client_select_pin_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe_n,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_n,
    output logic             wake_req
);
    // register state, pclk domain
    ssp_ctrl1_t      ctrl1;
    logic            boen;
    logic [7:0]      rx_buf;
    logic            buffer_full_flag;
    logic            port_irq_flag;
    logic            port_irq_enable;
    // host engine
    ssp_host_state_t hstate;
    logic [7:0]      hshift;
    logic [3:0]      hbits;
    logic [3:0]      hdiv;
    logic            hsck;
    logic            hsdo;
    logic [1:0]      sdi_sync;
    // client engine, link domain except csel_sync, which runs on pclk
    logic [7:0]      shift_register;
    logic [7:0]      crx_word;
    logic [3:0]      cbits;
    logic            cdone_tgl;
    logic [1:0]      ack_sync;
    logic [1:0]      cien_sync;
    logic [1:0]      cflag_sync;
    logic [1:0]      csel_sync;
    logic            cwake;
    // crossing back to pclk
    logic [2:0]      done_sync;
    logic            cli_on;
    logic            ack_tgl;

    wire is_client  = (ctrl1.mode >= MODE_CLIENT_MIN);
    wire is_host    = ctrl1.en && !is_client;
    wire use_sel    = (ctrl1.mode == MODE_CLIENT_SEL);
    wire setup      = psel && !penable;
    wire acc        = psel && penable && pready;
    wire wr_acc     = acc && pwrite;
    wire rd_acc     = acc && !pwrite;
    wire hit_buf    = (paddr == OFF_BUF);
    wire hit_c1     = (paddr == OFF_CTRL1);
    wire hit_c3     = (paddr == OFF_CTRL3);
    wire hit_st     = (paddr == OFF_STAT);
    wire hit_irq    = (paddr == OFF_IRQ);
    wire mapped     = hit_buf | hit_c1 | hit_c3 | hit_st | hit_irq;
    wire hbusy      = (hstate != SSP_IDLE);
    wire buf_wr     = wr_acc && hit_buf;
    wire buf_ok     = buf_wr && !ctrl1.write_collision_flag && !hbusy
                      && (!buffer_full_flag || boen || is_host);
    wire buf_coll   = buf_wr && hbusy;
    wire host_start = buf_ok && is_host;
    wire host_run   = hbusy && !sleep_req;                          // R1 R2
    wire tick       = host_run && (hdiv == HALF_BIT_CYC - 4'h1);
    wire host_done  = tick && (hstate == SSP_HIGH)
                      && (hbits == BITS_PER_BYTE - 4'h1);
    wire cli_done   = done_sync[2] ^ done_sync[1];
    wire byte_in    = host_done || (cli_done && ctrl1.en && is_client);
    wire [7:0] byte_val = host_done ? {hshift[6:0], sdi_sync[1]}
                                    : crx_word;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_buf)
            rd_mux[7:0] = rx_buf;
        else if (hit_c1)
            rd_mux[7:0] = ctrl1;
        else if (hit_c3)
            rd_mux[BIT_BOEN] = boen;
        else if (hit_st)
            rd_mux[BIT_BF] = buffer_full_flag;
        else if (hit_irq)
            rd_mux[1:0] = {port_irq_enable, port_irq_flag};
    end

    // apb answer: registered, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= setup ? rd_mux : 32'h0000_0000;
            pslverr <= setup && !mapped;
        end
    end

    // control and status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1           <= ssp_ctrl1_t'(RST_BYTE);
            boen            <= 1'b0;
            port_irq_enable <= 1'b0;
        end else begin
            if (wr_acc && hit_c1) begin
                ctrl1.en   <= pwdata[BIT_EN];
                ctrl1.clock_polarity_bit  <= pwdata[BIT_CKP];
                ctrl1.mode <= pwdata[3:0];
            end
            // collision / overflow set wins over software clear
            ctrl1.write_collision_flag <= buf_coll
                || (ctrl1.write_collision_flag && !(wr_acc && hit_c1 && !pwdata[BIT_WRITE_COLLISION_FLAG]));
            ctrl1.ov   <= (byte_in && buffer_full_flag)
                || (ctrl1.ov && !(wr_acc && hit_c1 && !pwdata[BIT_OV]));
            if (wr_acc && hit_c3)
                boen <= pwdata[BIT_BOEN];
            if (wr_acc && hit_irq)
                port_irq_enable <= pwdata[BIT_IEN];                 // R5
        end
    end

    // receive buffer, full flag and interrupt flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf           <= RST_BYTE;
            buffer_full_flag <= 1'b0;
            port_irq_flag    <= 1'b0;
        end else begin
            if (byte_in && !buffer_full_flag)
                rx_buf <= byte_val;                                 // R7
            buffer_full_flag <= byte_in
                || (buffer_full_flag && !(rd_acc && hit_buf));      // R7
            port_irq_flag <= byte_in                                // R4
                || (port_irq_flag
                    && !(wr_acc && hit_irq && pwdata[BIT_FLAG]));
        end
    end

    // host engine: mid-transfer every register holds while sleep_req is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hstate <= SSP_IDLE;
            hshift <= RST_BYTE;
            hbits  <= 4'h0;
            hdiv   <= 4'h0;
            hsck   <= 1'b0;
            hsdo   <= 1'b0;
        end else if (!ctrl1.en) begin
            hstate <= SSP_IDLE;
            hbits  <= 4'h0;                                         // R8
            hdiv   <= 4'h0;
            hsck   <= ctrl1.clock_polarity_bit;
        end else begin
            case (hstate)
                SSP_IDLE: begin
                    hsck <= ctrl1.clock_polarity_bit;
                    if (host_start) begin
                        hshift <= pwdata[7:0];
                        hsdo   <= pwdata[7];
                        hbits  <= 4'h0;
                        hdiv   <= 4'h0;
                        hstate <= SSP_LOW;
                    end
                end
                SSP_LOW: begin
                    if (host_run)                                   // R1
                        hdiv <= tick ? 4'h0 : hdiv + 4'h1;
                    if (tick) begin
                        hsck   <= !ctrl1.clock_polarity_bit;
                        hstate <= SSP_HIGH;
                    end
                end
                SSP_HIGH: begin
                    if (host_run)                                   // R2
                        hdiv <= tick ? 4'h0 : hdiv + 4'h1;
                    if (tick) begin
                        hsck   <= ctrl1.clock_polarity_bit;
                        hshift <= {hshift[6:0], sdi_sync[1]};
                        hsdo   <= hshift[6];
                        hbits  <= hbits + 4'h1;
                        hstate <= host_done ? SSP_IDLE : SSP_LOW;
                    end
                end
                default: hstate <= SSP_IDLE;
            endcase
        end
    end

    // pin-side synchronisers and registered pin drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdi_sync              <= 2'b00;
            done_sync             <= 3'b000;
            sdo                   <= 1'b0;
            sdo_oe_n              <= 1'b1;
            serial_clock_pin_o    <= 1'b0;
            serial_clock_pin_oe_n <= 1'b1;
            csel_sync             <= 2'b11;
            cli_on                <= 1'b0;
            ack_tgl               <= 1'b0;
        end else begin
            sdi_sync              <= {sdi_sync[0], sdi};
            done_sync             <= {done_sync[1:0], cdone_tgl};
            csel_sync             <= {csel_sync[0],
                                      client_select_pin_n || !use_sel};
            cli_on                <= ctrl1.en && is_client;
            // ack follows the byte toggle once the flag is clear
            ack_tgl               <= (port_irq_flag || cli_done)
                                     ? ack_tgl : done_sync[2];
            sdo                   <= is_host ? hsdo : shift_register[7];
            sdo_oe_n              <= !(is_host || (ctrl1.en && is_client
                                       && !(use_sel && csel_sync[1])));
            serial_clock_pin_o    <= hsck;
            serial_clock_pin_oe_n <= !is_host;
        end
    end

    // client engine, clocked only by the serial clock pin
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            cien_sync  <= 2'b00;
            cflag_sync <= 2'b00;
            ack_sync   <= 2'b00;
        end else begin
            cien_sync  <= {cien_sync[0], port_irq_enable};
            cflag_sync <= {cflag_sync[0], port_irq_flag};
            ack_sync   <= {ack_sync[0], ack_tgl};
        end
    end

    // counter reset: power-on, port off or select high; the first edge
    // of a frame is kept because no link edge is needed to release it
    wire cli_rst_n = presetn && cli_on
                     && !(use_sel && client_select_pin_n);          // R8
    wire cli_last  = (cbits == BITS_PER_BYTE - 4'h1);
    // wake stays until the pclk side has taken the byte and the flag fell
    wire cli_pend  = cwake && ((ack_sync[1] != cdone_tgl) || cflag_sync[1]);

    always_ff @(posedge link_clk or negedge cli_rst_n) begin
        if (!cli_rst_n) begin
            shift_register <= RST_BYTE;
            cbits          <= 4'h0;                                 // R8
        end else begin
            shift_register <= {shift_register[6:0], sdi};           // R3
            cbits          <= cli_last ? 4'h0 : cbits + 4'h1;
        end
    end

    // hand-over toggle and wake reset only at power-on, so the toggle
    // pair with the pclk side never loses step
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            crx_word  <= RST_BYTE;
            cdone_tgl <= 1'b0;
            cwake     <= 1'b0;
        end else begin
            if (cli_last) begin
                crx_word  <= {shift_register[6:0], sdi};
                cdone_tgl <= !cdone_tgl;                            // R4
            end
            // wake raised here so it needs no pclk edge
            cwake <= (cli_last || cli_pend) && cien_sync[1];        // R9 R5
        end
    end

    always_comb wake_req = cwake;
endmodule
`default_nettype wire

//--- ssp_sleep_port_props.sv
/* assertions on the pins of the sleep-aware serial port.
   assumes every assertion runs on pclk with presetn as reset. */
`default_nettype none
module ssp_sleep_port_props
    import ssp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        sleep_req,
    input wire logic        link_clk,
    input wire logic        client_select_pin_n,
    input wire logic        sdi,
    input wire logic        sdo,
    input wire logic        sdo_oe_n,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe_n,
    input wire logic        wake_req
);
    wire logic mapped;
    assign mapped = paddr == OFF_BUF || paddr == OFF_CTRL1
        || paddr == OFF_CTRL3 || paddr == OFF_STAT || paddr == OFF_IRQ;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    err_map_a: assert property (pready |-> pslverr == !$past(mapped))
        else $error("error flag does not match address map");
    err_data_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    host_freeze_a: assert property (
        !serial_clock_pin_oe_n && sleep_req && $past(sleep_req)
        && $past(sleep_req, 2)
        |-> $stable(serial_clock_pin_o) && $stable(sdo))
        else $error("host pins moved during sleep");
    wake_hold_a: assert property ($rose(wake_req) |=> wake_req[*3])
        else $error("wake request too short");
endmodule
bind ssp_sleep_port ssp_sleep_port_props u_ssp_sleep_port_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .sleep_req, .link_clk, .client_select_pin_n, .sdi,
    .sdo, .sdo_oe_n, .serial_clock_pin_o, .serial_clock_pin_oe_n, .wake_req
);
`default_nettype wire

//--- ssp_sleep_port_test.sv
/* self-checking bench for the sleep-aware serial port.
   assumes the link host model and the bound checker are compiled. */
`default_nettype none
module ssp_sleep_port_test
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, sleep_req;
    logic        pready, pslverr, sdo, sdo_oe_n, sck_o, sck_oe_n;
    logic        wake_req, link_clk, ss_n, sdi;
    logic [7:0]  paddr, rd, b;
    logic [31:0] pwdata, prdata;
    logic [8:0]  note;
    logic [8:0]  exp_q[$];
    int          errors, checks_done, edges, seed, n0;

    always #20 pclk = ~pclk;
    always @(posedge sck_o) edges++;

    ssp_sleep_port u_ssp_sleep_port (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .sleep_req,
        .link_clk, .client_select_pin_n(ss_n), .sdi, .sdo, .sdo_oe_n,
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .wake_req);
    ssp_link_host u_ssp_link_host (.link_clk, .ss_n, .sdi);

    task automatic check(input string what, input logic [7:0] e, s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, d,
                       input logic nt, input logic [8:0] e);
        int n;
        if (nt) exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("[FAIL] pready expected 1 seen %b", pready);
        end
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic client(input logic [7:0] v, input int n);
        u_ssp_link_host.frame(v, n, 1'b1);
        repeat (4) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check("read data", note[7:0], prdata[7:0]);
            check("slave error", {7'h0, note[8]}, {7'h0, pslverr});
        end
    end
    task automatic print_verdict;
        if (exp_q.size() != 0) errors++;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        print_verdict();
    end
    initial begin
        seed = 32'hec8f;
        {pclk, presetn, psel, penable, pwrite, sleep_req} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fork
            u_ssp_link_host.frame(8'h00, 2, 1'b0);
        join_none
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) apb(0, 8'(i * 4), 0, 1, {i == 5, RST_BYTE});
        b = 8'($random(seed));
        u_ssp_link_host.level(b[0]);
        apb(1, OFF_CTRL1, 8'h20, 0, 0);
        apb(1, OFF_BUF, 8'ha5, 0, 0);
        apb(1, OFF_BUF, 8'h5a, 0, 0);
        apb(0, OFF_CTRL1, 0, 1, 9'h0a0);
        sleep_req <= 1'b1;
        repeat (3) @(posedge pclk);
        n0 = edges;
        repeat (37) @(posedge pclk);
        check("frozen clock", 8'(n0), 8'(edges));
        sleep_req <= 1'b0;
        n0 = 0;
        do begin
            apb(0, OFF_STAT, 0, 0, 0);
            n0++;
        end while (rd[BIT_BF] !== 1'b1 && n0 < 60);
        check("buffer full", 8'h01, {7'h0, rd[BIT_BF]});
        check("host edges", 8'h08, 8'(edges));
        apb(0, OFF_BUF, 0, 1, {1'b0, {8{b[0]}}});
        apb(0, OFF_STAT, 0, 1, 9'h000);
        apb(1, OFF_CTRL1, 8'h00, 0, 0);
        apb(1, OFF_IRQ, 8'h02, 0, 0);
        apb(1, OFF_CTRL1, 8'h24, 0, 0);
        sleep_req <= 1'b1;
        b = 8'($random(seed));
        client(b, 8);
        check("wake", 8'h01, {7'h0, wake_req});
        apb(0, OFF_BUF, 0, 1, {1'b0, b});
        apb(0, OFF_IRQ, 0, 1, 9'h003);
        apb(1, OFF_IRQ, 8'h03, 0, 0);
        client(8'h00, 3);
        check("wake clear", 8'h00, {7'h0, wake_req});
        client(~b, 3);
        b = 8'($random(seed));
        client(b, 8);
        apb(0, OFF_BUF, 0, 1, {1'b0, b});
        apb(1, OFF_IRQ, 8'h01, 0, 0);
        b = 8'($random(seed));
        client(b, 8);
        check("no wake", 8'h00, {7'h0, wake_req});
        apb(0, OFF_IRQ, 0, 1, 9'h001);
        apb(0, OFF_STAT, 0, 1, 9'h001);
        apb(0, OFF_BUF, 0, 1, {1'b0, b});
        print_verdict();
    end
endmodule
`default_nettype wire
